// ==== dv/data_mem_addr_monitor.sv ====
`timescale 1ns/1ps
module data_mem_addr_monitor
	import data_mem_pkg::*;
(
	// clock, reset, config
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       big_variant,
	// instruction and bank pointer
	input wire instr_t     instr,
	input wire logic       bank_ptr_wr,
	input wire logic [7:0] bank_ptr_wdata,
	input wire logic [7:0] bank_ptr_rdata,
	// results
	input wire read_resp_t rd_resp,
	input wire logic       status_update,
	input wire logic       nop_exec,
	input wire logic [11:0] literal12,
	input wire logic       literal_valid
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic [1:0]  q_reg;
	logic        two_reg;
	logic [3:0]  wd_reg;
	logic [11:0] lit_reg;
	logic        take;
	logic        tk2;
	logic        file;
	assign take = !rst && q_reg == 2'h0 && instr.valid;
	assign tk2 = take && instr.kind == OP_NONE && instr.word[15:12] == 4'hf;
	assign file = take && instr.kind == OP_FILE;
	////////////////////////////////
	always_ff @(posedge clk) begin
		q_reg <= rst ? 2'h0 : q_reg + 2'h1;
		two_reg <= rst ? 1'b0 : (take ? instr.kind inside
			{OP_CALL_ABS, OP_JUMP_ABS, OP_FULL_MOVE, OP_PTR_LOAD} : two_reg);
		wd_reg <= bank_ptr_wr ? bank_ptr_wdata[3:0] : wd_reg;
		lit_reg <= tk2 ? instr.word[11:0] : lit_reg;
	end
	a_resp_delay: assert property (file |-> ##3 rd_resp.valid)
		else $error("operand read late");
	a_banked_addr: assert property (file && instr.access_sel
		|-> ##3 {4'h0, rd_resp.addr[11:8]} == $past(bank_ptr_rdata, 3) &&
		rd_resp.addr[7:0] == $past(instr.offset, 3))
		else $error("banked address wrong");
	a_access_map: assert property (file && !instr.access_sel
		|-> ##3 rd_resp.addr == ($past(instr.offset, 3) < 8'h60 ?
		{4'h0, $past(instr.offset, 3)} : {4'hf, $past(instr.offset, 3)}))
		else $error("access map wrong");
	a_zero_unimpl: assert property (rd_resp.valid &&
		!rd_resp.implemented |-> rd_resp.data == 8'h00)
		else $error("unimplemented not zero");
	// the flag is formed one edge before it shows, with the config then
	a_impl_flag: assert property (rd_resp.valid |->
		rd_resp.implemented ==
		(rd_resp.addr[11:8] < ($past(big_variant) ? 4'h8 : 4'h4)))
		else $error("implemented flag wrong");
	a_bank_write: assert property (bank_ptr_wr |=> ##[0:1]
		bank_ptr_rdata == {4'h0, wd_reg}) else $error("bank write lost");
	a_status_after: assert property (file && instr.wr_en |-> ##4
		status_update) else $error("status not updated");
	a_lone_nop: assert property (tk2 && !two_reg |-> ##[1:4]
		nop_exec) else $error("lone word not no-op");
	a_literal_use: assert property (tk2 && two_reg |-> ##[1:4]
		(literal_valid && literal12 == lit_reg))
		else $error("literal not consumed");
	a_full_move: assert property (take &&
		instr.kind == OP_FULL_MOVE |-> ##3
		rd_resp.addr == $past(instr.full_addr, 3))
		else $error("full move address wrong");
endmodule : data_mem_addr_monitor

bind data_mem_addr data_mem_addr_monitor mon (.clk(clk), .rst(rst),
	.big_variant(big_variant), .instr(instr), .bank_ptr_wr(bank_ptr_wr),
	.bank_ptr_wdata(bank_ptr_wdata), .bank_ptr_rdata(bank_ptr_rdata),
	.rd_resp(rd_resp), .status_update(status_update), .nop_exec(nop_exec),
	.literal12(literal12), .literal_valid(literal_valid));

// ==== dv/fetch_stub.sv ====
`timescale 1ns/1ps
module fetch_stub (
	// clock and reset
	input  wire logic           clk,
	input  wire logic           rst,
	// decoded word toward the block
	output data_mem_pkg::instr_t instr
);
	import data_mem_pkg::*;
	logic [1:0] q_reg;
	initial instr = '0;
	always_ff @(posedge clk) begin
		q_reg <= rst ? 2'h0 : q_reg + 2'h1;
	end
	// one word per instruction cycle; pairs go out back to back
	task automatic issue(input instr_t w);
		instr_t idle;
		// released word toggles so stale fields never look valid
		idle = ~w;
		idle.valid = 1'b0;
		@(negedge clk);
		// bounded: a stuck counter shows up as a missed answer
		for (int i = 0; i < 8 && (rst || q_reg != 2'h0); i++) @(negedge clk);
		instr = w;
		@(negedge clk);
		instr = idle;
	endtask : issue
endmodule : fetch_stub

// ==== dv/test_banked_data_memory_addressing.sv ====
`timescale 1ns/1ps
module test_banked_data_memory_addressing;
	import data_mem_pkg::*;
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
	typedef struct packed {
		logic [3:0]  bank;
		logic        a;
		logic [7:0]  off;
		logic        wr;
		logic [7:0]  wd;
		logic [11:0] ea;
		logic        ei;
		logic [7:0]  ed;
	} row_t;
	logic       clk, rst, big, bwr, stu, nop, litv, rv;
	logic [7:0] bwd, brd;
	logic [11:0] lit;
	instr_t     instr;
	read_resp_t resp;
	int         error_cnt, tests_run;
	row_t rows [8] = '{
		'{4'h2, 1'b1, 8'h34, 1'b1, 8'ha5, 12'h234, 1'b1, 8'h00},
		'{4'h2, 1'b1, 8'h34, 1'b0, 8'h00, 12'h234, 1'b1, 8'ha5},
		'{4'h7, 1'b0, 8'h12, 1'b1, 8'h3c, 12'h012, 1'b1, 8'h00},
		'{4'h9, 1'b0, 8'h12, 1'b0, 8'h00, 12'h012, 1'b1, 8'h3c},
		'{4'h9, 1'b1, 8'h12, 1'b1, 8'h77, 12'h912, 1'b0, 8'h00},
		'{4'h9, 1'b1, 8'h12, 1'b0, 8'h00, 12'h912, 1'b0, 8'h00},
		'{4'h3, 1'b0, 8'h60, 1'b0, 8'h00, 12'hf60, 1'b0, 8'h00},
		'{4'h4, 1'b1, 8'h00, 1'b0, 8'h00, 12'h400, 1'b0, 8'h00}};
	assign rv = resp.valid;
	data_mem_addr dut (.clk(clk), .rst(rst), .ext_set_enable(1'b0),
		.big_variant(big), .instr(instr), .bank_ptr_wr(bwr),
		.bank_ptr_wdata(bwd), .bank_ptr_rdata(brd), .rd_resp(resp),
		.status_update(stu), .nop_exec(nop), .literal12(lit),
		.literal_valid(litv));
	fetch_stub stub (.clk(clk), .rst(rst), .instr(instr));
	////////////////////////////////
	task automatic complete_run();
		$display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : complete_run
	task automatic wait_bit(ref logic f);
		for (int i = 0; i < 8 && f !== 1'b1; i++) @(negedge clk);
		`CHK(f, 1'b1)
		if (f !== 1'b1) complete_run();
	endtask : wait_bit
	function automatic instr_t mk(op_kind_t k, logic a, logic [7:0] o,
		logic w, logic [7:0] d, logic [15:0] x);
		instr_t r;
		r = '{1'b1, k, a, o, x[11:0], x, w, d};
		return r;
	endfunction : mk
	task automatic set_bank(input logic [7:0] v);
		@(negedge clk);
		bwr = 1'b1;
		bwd = v;
		@(negedge clk);
		bwr = 1'b0;
		@(negedge clk);
		`CHK(brd, {4'h0, v[3:0]})
	endtask : set_bank
	task automatic op(op_kind_t k, logic a, logic [7:0] o, logic w,
		logic [7:0] d, logic [15:0] x);
		stub.issue(mk(k, a, o, w, d, x));
		if (k == OP_FILE || k == OP_FULL_MOVE) wait_bit(rv);
	endtask : op
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		{rst, big, bwr, bwd} = {1'b1, 10'h000};
		repeat (20) @(negedge clk);
		rst = 1'b0;
		foreach (rows[i]) begin
			set_bank({4'ha, rows[i].bank});
			op(OP_FILE, rows[i].a, rows[i].off, rows[i].wr, rows[i].wd, 0);
			`CHK(resp.addr, rows[i].ea)
			`CHK(resp.implemented, rows[i].ei)
			if (!rows[i].wr) `CHK(resp.data, rows[i].ed)
			@(negedge clk);
			`CHK(stu, rows[i].wr)
			$display("row %0d done", i);
		end
		// larger variant opens banks 4 to 7
		big = 1'b1;
		set_bank(8'h05);
		op(OP_FILE, 1'b1, 8'h20, 1'b1, 8'hc3, 0);
		op(OP_FILE, 1'b1, 8'h20, 1'b0, 8'h00, 0);
		`CHK(resp.data, 8'hc3)
		$display("variant done");
		op(OP_BANK_LOAD, 1'b0, 8'h00, 1'b0, 8'hf6, 0);
		for (int i = 0; i < 8 && brd !== 8'h06; i++) @(negedge clk);
		`CHK(brd, 8'h06)
		if (brd !== 8'h06) complete_run();
		op(OP_FULL_MOVE, 1'b1, 8'h00, 1'b0, 8'h00, 16'h0234);
		`CHK(resp.addr, 12'h234)
		`CHK(resp.data, 8'ha5)
		op(OP_NONE, 1'b0, 8'h00, 1'b0, 8'h00, 16'hf456);
		wait_bit(litv);
		`CHK(lit, 12'h456)
		op(OP_NONE, 1'b0, 8'h00, 1'b0, 8'h00, 16'hf789);
		wait_bit(nop);
		// full move writes the trailing word's data, not its source byte, at that word's address
		op(OP_FULL_MOVE, 1'b1, 8'h00, 1'b0, 8'h00, 16'h0012);
		`CHK(resp.data, 8'h3c)
		op(OP_NONE, 1'b0, 8'h00, 1'b1, 8'h5a, 16'hf045);
		op(OP_FILE, 1'b0, 8'h45, 1'b0, 8'h00, 0);
		`CHK(resp.data, 8'h5a)
		$display("two-word done");
		// mid-run reset clears the pointer but keeps the RAM
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		`CHK(brd, 8'h00)
		set_bank(8'h02);
		op(OP_FILE, 1'b1, 8'h34, 1'b0, 8'h00, 0);
		`CHK(resp.data, 8'ha5)
		$display("reset done");
		complete_run();
	end
endmodule : test_banked_data_memory_addressing

// ==== logic/addr_former.sv ====
`timescale 1ns/1ps
module addr_former (
	// operand select
	input  wire logic                          access_sel,
	input  wire logic                          ext_set_enable,
	input  wire logic [data_mem_pkg::OFFS_W-1:0] offset,
	input  wire logic [data_mem_pkg::BANK_W-1:0] bank,
	// result
	output logic      [data_mem_pkg::ADDR_W-1:0] addr
);
	import data_mem_pkg::*;

	always_comb begin
		if (access_sel) begin
			addr = {bank, offset};
		end else if (offset < ACCESS_SPLIT) begin
			addr = {ACCESS_LO_BANK, offset};
		end else begin
			addr = {ACCESS_HI_BANK, offset};
		end
		// ext_set_enable: indexed remap lives in the core's alternative path
		if (ext_set_enable && !access_sel) begin
			addr = addr;
		end
	end

endmodule : addr_former

// ==== logic/data_mem_addr.sv ====
`timescale 1ns/1ps
module data_mem_addr (
	// clock and reset
	input  wire logic                           clk,
	input  wire logic                           rst,
	// configuration
	input  wire logic                           ext_set_enable,
	input  wire logic                           big_variant,
	// instruction from the decoder, one per instruction cycle
	input  wire data_mem_pkg::instr_t           instr,
	// bank pointer register access
	input  wire logic                           bank_ptr_wr,
	input  wire logic [data_mem_pkg::DATA_W-1:0] bank_ptr_wdata,
	output logic      [data_mem_pkg::DATA_W-1:0] bank_ptr_rdata,
	// operand result
	output data_mem_pkg::read_resp_t            rd_resp,
	output logic                                status_update,
	output logic                                nop_exec,
	output logic      [data_mem_pkg::ADDR_W-1:0] literal12,
	output logic                                literal_valid
);
	import data_mem_pkg::*;

	typedef struct packed {
		logic [1:0]          q;
		logic [BANK_W-1:0]   bank_ptr;
		logic                pend_two;
		op_kind_t            pend_kind;
		logic                second;
		instr_t              cur;
		logic [ADDR_W-1:0]   op_addr;
		logic [ADDR_W-1:0]   src_addr;
		logic                op_impl;
		read_resp_t          resp;
		logic                status_upd;
		logic                nop;
		logic [ADDR_W-1:0]   lit;
		logic                lit_valid;
	} state_t;

	state_t st_reg;
	state_t st_next;

	logic [ADDR_W-1:0]    banked_addr;
	logic [RAM_IDX_W-1:0] ram_rd_idx;
	logic [RAM_IDX_W-1:0] ram_wr_idx;
	logic                 ram_rd_en;
	logic                 ram_wr_en;
	logic [DATA_W-1:0]    ram_rd_data;

	////////////////////////////////////////////////////////////////////////
	// decoding helpers

	function automatic logic addr_implemented(input logic [ADDR_W-1:0] a,
	                                          input logic big);
		logic [BANK_W-1:0] b;
		b = a[ADDR_W-1 -: BANK_W];
		// bank 15 special registers belong to peripherals, not here
		if (big) begin
			return b < 4'h8;
		end
		return b < 4'h4;
	endfunction : addr_implemented

	function automatic logic [RAM_IDX_W-1:0] ram_index(
		input logic [ADDR_W-1:0] a);
		return a[RAM_IDX_W-1:0];
	endfunction : ram_index

	// a full move writes only once its trailing word names the target
	function automatic logic writes_dest(input op_kind_t k,
	                                     input logic     sec);
		return (k == OP_FILE) || (k == OP_FULL_MOVE && sec);
	endfunction : writes_dest

	////////////////////////////////////////////////////////////////////////
	// address forming

	addr_former u_addr_former (
		.access_sel     (st_reg.cur.access_sel),
		.ext_set_enable (ext_set_enable),
		.offset         (st_reg.cur.offset),
		.bank           (st_reg.bank_ptr),
		.addr           (banked_addr)
	);

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		st_next            = st_reg;
		st_next.q          = st_reg.q + 2'h1;
		st_next.status_upd = 1'b0;
		st_next.resp.valid = 1'b0;
		st_next.nop        = 1'b0;
		st_next.lit_valid  = 1'b0;

		// q0: latch a new instruction word
		if (st_reg.q == 2'h0) begin
			st_next.cur = instr;
			st_next.second = 1'b0;
			if (!instr.valid) begin
				st_next.cur.kind = OP_NONE;
			end else if (st_reg.pend_two && is_second_word(instr.word)) begin
				// trailing word consumed by its own instruction
				st_next.lit       = instr.word[ADDR_W-1:0];
				st_next.lit_valid = 1'b1;
				st_next.cur.kind  = st_reg.pend_kind;
				st_next.second    = 1'b1;
				st_next.pend_two  = 1'b0;
			end else if (is_second_word(instr.word)) begin
				st_next.cur.kind = OP_NONE;
				st_next.nop      = 1'b1;
				st_next.pend_two = 1'b0;
			end else begin
				st_next.pend_two  = is_two_word(instr.kind);
				st_next.pend_kind = instr.kind;
			end
		end

		// q1: resolve the operand address before the read
		if (st_reg.q == 2'h0) begin
			st_next.op_impl = 1'b0;
		end
		if (st_reg.q == Q_READ) begin
			if (st_reg.cur.kind == OP_FULL_MOVE) begin
				// destination arrives in the trailing word
				st_next.op_addr = st_reg.lit_valid ? st_reg.lit
				                                   : st_reg.cur.full_addr;
				st_next.src_addr = st_reg.cur.full_addr;
			end else begin
				st_next.op_addr  = banked_addr;
				st_next.src_addr = banked_addr;
			end
		end

		// q2: operand read result
		// a full move reports its source read from the first word only
		if (st_reg.q == 2'h2 && (st_reg.cur.kind == OP_FILE ||
		    (st_reg.cur.kind == OP_FULL_MOVE && !st_reg.second))) begin
			st_next.resp.valid       = 1'b1;
			st_next.resp.addr        = st_reg.src_addr;
			st_next.resp.implemented = addr_implemented(st_reg.src_addr,
			                                            big_variant);
			st_next.resp.data        = st_next.resp.implemented
			                           ? ram_rd_data : '0;
		end

		// q3: destination write; flags follow even when discarded
		if (st_reg.q == Q_WRITE) begin
			if (st_reg.cur.kind == OP_BANK_LOAD) begin
				st_next.bank_ptr = st_reg.cur.wr_data[BANK_W-1:0];
			end
			if (writes_dest(st_reg.cur.kind, st_reg.second)) begin
				st_next.status_upd = st_reg.cur.wr_en;
			end
		end

		if (bank_ptr_wr) begin
			st_next.bank_ptr = bank_ptr_wdata[BANK_W-1:0];
		end

		if (rst) begin
			st_next           = '0;
			st_next.bank_ptr  = BANK_PTR_RESET;
			st_next.cur.kind  = OP_NONE;
			st_next.pend_kind = OP_NONE;
		end
	end

	always_ff @(posedge clk) begin
		st_reg <= st_next;
	end

	////////////////////////////////////////////////////////////////////////
	// memory ports: read launched in q1, write in q3

	always_comb begin
		ram_rd_idx = ram_index(st_next.src_addr);
		ram_rd_en  = (st_reg.q == Q_READ) && !rst;
		ram_wr_idx = ram_index(st_reg.op_addr);
		ram_wr_en  = (st_reg.q == Q_WRITE) && !rst &&
		             st_reg.cur.wr_en &&
		             writes_dest(st_reg.cur.kind, st_reg.second) &&
		             addr_implemented(st_reg.op_addr, big_variant);
	end

	gp_ram u_gp_ram (
		.clk     (clk),
		.wr_en   (ram_wr_en),
		.wr_idx  (ram_wr_idx),
		.wr_data (st_reg.cur.wr_data),
		.rd_en   (ram_rd_en),
		.rd_idx  (ram_rd_idx),
		.rd_data (ram_rd_data)
	);

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign bank_ptr_rdata = {4'h0, st_reg.bank_ptr};
	assign rd_resp        = st_reg.resp;
	assign status_update  = st_reg.status_upd;
	assign nop_exec       = st_reg.nop;
	assign literal12      = st_reg.lit;
	assign literal_valid  = st_reg.lit_valid;

endmodule : data_mem_addr

// ==== logic/data_mem_pkg.sv ====
// Operation
// - four two-word instructions: absolute call, absolute jump, full move, pointer load.
// - second word has 1111 in top four bits, low 12 bits literal.
// - second word right after its first word supplies literal to that instruction.
// - 1111 word executed alone, e.g. after a skip, acts as no-op.
// - every data location has a 12-bit address, up to 4096 bytes.
// - address space is 16 contiguous banks of 256 bytes.
// - implemented RAM is 4 banks (1024) or 8 banks (2048) by variant.
// - reads of unimplemented locations return zero.
// - banked access: bank pointer gives top 4 bits, instruction low 8.
// - bank pointer upper four bits read zero and ignore writes.
// - load-bank-literal writes its literal into the bank pointer.
// - unimplemented bank writes dropped, reads zero, status still updates.
// - full-address move uses 12-bit addresses from its words, ignoring bank pointer.
// - access bank: 00h-5Fh to bank 0 start, 60h-FFh to bank 15 end.
// - access-select 1 uses bank pointer; 0 uses access bank map.
// - extended-set enable changes access map; alternative is handled elsewhere.
// - general purpose RAM is not initialised and survives all resets.
// - operand read in second quarter-cycle, destination written in fourth.
package data_mem_pkg;

	localparam int ADDR_W       = 12;
	localparam int DATA_W       = 8;
	localparam int OFFS_W       = 8;
	localparam int BANK_W       = 4;
	localparam int RAM_BANKS    = 8;
	localparam int RAM_DEPTH    = RAM_BANKS * 256;
	localparam int RAM_IDX_W    = 11;
	localparam logic [7:0] ACCESS_SPLIT    = 8'h60;
	localparam logic [3:0] ACCESS_HI_BANK  = 4'hf;
	localparam logic [3:0] ACCESS_LO_BANK  = 4'h0;
	localparam logic [3:0] SECOND_WORD_TAG = 4'hf;
	localparam logic [3:0] BANK_PTR_RESET  = 4'h0;
	localparam logic [1:0] Q_READ          = 2'h1;
	localparam logic [1:0] Q_WRITE         = 2'h3;

	typedef enum logic [2:0] {
		OP_NONE       = 3'b000,
		OP_CALL_ABS   = 3'b001,
		OP_JUMP_ABS   = 3'b010,
		OP_FULL_MOVE  = 3'b011,
		OP_PTR_LOAD   = 3'b100,
		OP_BANK_LOAD  = 3'b101,
		OP_FILE       = 3'b110
	} op_kind_t;

	// one decoded instruction word as the pipeline hands it over
	typedef struct packed {
		logic                valid;
		op_kind_t            kind;
		logic                access_sel;
		logic [OFFS_W-1:0]   offset;
		logic [ADDR_W-1:0]   full_addr;
		logic [15:0]         word;
		logic                wr_en;
		logic [DATA_W-1:0]   wr_data;
	} instr_t;

	typedef struct packed {
		logic                valid;
		logic [DATA_W-1:0]   data;
		logic [ADDR_W-1:0]   addr;
		logic                implemented;
	} read_resp_t;

	function automatic logic is_two_word(input op_kind_t k);
		return (k == OP_CALL_ABS) || (k == OP_JUMP_ABS) ||
		       (k == OP_FULL_MOVE) || (k == OP_PTR_LOAD);
	endfunction : is_two_word

	function automatic logic is_second_word(input logic [15:0] w);
		return w[15:12] == SECOND_WORD_TAG;
	endfunction : is_second_word

endpackage : data_mem_pkg

// ==== logic/gp_ram.sv ====
`timescale 1ns/1ps
module gp_ram (
	// clock
	input  wire logic                             clk,
	// write port
	input  wire logic                             wr_en,
	input  wire logic [data_mem_pkg::RAM_IDX_W-1:0] wr_idx,
	input  wire logic [data_mem_pkg::DATA_W-1:0]    wr_data,
	// read port
	input  wire logic                             rd_en,
	input  wire logic [data_mem_pkg::RAM_IDX_W-1:0] rd_idx,
	output logic      [data_mem_pkg::DATA_W-1:0]    rd_data
);
	import data_mem_pkg::*;

	// no reset: contents survive every reset and start undefined
	logic [DATA_W-1:0] mem [RAM_DEPTH];

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_idx] <= wr_data;
		end
		if (rd_en) begin
			rd_data <= mem[rd_idx];
		end
	end

endmodule : gp_ram
